//--- include/fws_consts.vh
// Constants for the flash write status-word logic
// Notes on behaviour
// - Pulse limit exceeded sets timing-limit flag
// - Programming a 0 to 1 halts, flags later
// - Program clears bits only; erase sets them
// - Reset command clears failure, back to read (to erase suspend from erase-suspend program)
// - Erase-window flag 0 in time-out, then 1
// - Each added sector restarts full time-out
// - Chip erase skips the acceptance window
// - Erase running: ignore all but suspend, and reset once the limit flag is set
// - Window open: add sectors to pending set
// - Buffer abort drives buffer-abort flag high
// - Abort-reset command returns to array read
// - Polling and second toggle need valid address
// - Program-suspended sector reads not guaranteed
// - Buffer polling is ~bit7 of last load
// - First toggle inverts per status read busy
// - Second toggle inverts in selected sectors
`ifndef FWS_CONSTS_VH
`define FWS_CONSTS_VH
`define FWS_SECTORS 131
`define FWS_SEC_W 8
`define FWS_CMD_W 4
`define FWS_CMD_NONE 4'h0
`define FWS_CMD_PROG 4'h1
`define FWS_CMD_BUF_PROG 4'h2
`define FWS_CMD_SEC_ERASE 4'h3
`define FWS_CMD_CHIP_ERASE 4'h4
`define FWS_CMD_ERS_SUSP 4'h5
`define FWS_CMD_ERS_RESUME 4'h6
`define FWS_CMD_PRG_SUSP 4'h7
`define FWS_CMD_PRG_RESUME 4'h8
`define FWS_CMD_RESET 4'h9
`define FWS_CMD_ABORT_RESET 4'ha
`define FWS_CMD_BUF_ABORT 4'hb
`define FWS_ERASE_TMO_US 50
`define FWS_CLK_MHZ 100
`define FWS_ERASE_TMO_CYC (`FWS_ERASE_TMO_US * `FWS_CLK_MHZ)
`define FWS_PULSE_LIMIT 1000
`define FWS_CNT_W 16
`endif

//--- verilog/fws_toggle_pair.v
// Toggle-bit pair; each bit advances on a status read while its enable is set
`timescale 1ns/1ps
`default_nettype none
module fws_toggle_pair (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Control
  input wire stat_rd,
  input wire first_en,
  input wire second_en,
  // Bits
  output reg first_toggle_bit,
  output reg second_toggle_bit
);
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_toggle_bit <= 1'b0;
      second_toggle_bit <= 1'b0;
    end else if (stat_rd) begin
      if (first_en)
        first_toggle_bit <= ~first_toggle_bit;
      if (second_en)
        second_toggle_bit <= ~second_toggle_bit;
    end
  end
endmodule
`default_nettype wire

//--- verilog/fws_status.v
// Status-word sequencer for embedded program and erase
`timescale 1ns/1ps
`default_nettype none
`include "fws_consts.vh"
module fws_status #(
  parameter ERASE_TMO_CYC = `FWS_ERASE_TMO_CYC,
  parameter PULSE_LIMIT = `FWS_PULSE_LIMIT
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Command strobe
  input wire cmd_valid,
  input wire [3:0] cmd_code,
  input wire [7:0] cmd_sector,
  input wire [15:0] cmd_data,
  // Array content at the program location
  input wire [15:0] array_word,
  // Embedded algorithm progress
  input wire op_pulse,
  input wire op_done,
  // Status read
  input wire stat_rd,
  input wire [7:0] rd_sector,
  input wire rd_addr_last,
  input wire [15:0] rd_array,
  // Status outputs
  output reg [15:0] rd_data,
  output wire busy,
  output wire erase_running,
  output wire [2:0] state
);
  localparam S_READ = 3'd0;
  localparam S_PROG = 3'd1;
  localparam S_EWIN = 3'd2;
  localparam S_ERASE = 3'd3;
  localparam S_ESUSP = 3'd4;
  localparam S_ESPROG = 3'd5;
  localparam S_PSUSP = 3'd6;
  localparam S_BUF = 3'd7;

  reg [2:0] st_q, st_d;
  reg [`FWS_SECTORS-1:0] sel_q;
  reg [`FWS_SEC_W-1:0] prog_sec_q;
  reg [`FWS_CNT_W-1:0] tmo_q;
  reg [`FWS_CNT_W-1:0] pulse_q;
  reg limit_q;
  reg abort_q;
  reg halt_q;
  reg chip_q;
  reg poll7_q;
  wire [`FWS_SECTORS-1:0] cmd_hot;
  wire in_sel;
  wire t1_en;
  wire t2_en;
  wire tb1;
  wire tb2;

  function is_cmd;
    input [3:0] code;
    begin
      is_cmd = cmd_valid && (cmd_code == code);
    end
  endfunction

  assign cmd_hot = {{(`FWS_SECTORS-1){1'b0}}, 1'b1} << cmd_sector;
  assign in_sel = (rd_sector < `FWS_SECTORS) ? sel_q[rd_sector] : 1'b0;
  assign busy = (st_q != S_READ) && (st_q != S_ESUSP) && (st_q != S_PSUSP);
  assign erase_running = (st_q == S_ERASE);
  assign state = st_q;
  // First toggle keeps running after a fault; the limit flag tells a stall apart
  assign t1_en = (st_q == S_PROG) || (st_q == S_EWIN) || (st_q == S_ERASE) ||
                 (st_q == S_ESPROG) || (st_q == S_BUF);
  assign t2_en = ((st_q == S_ERASE) || (st_q == S_EWIN) || (st_q == S_ESUSP)) && in_sel;

  fws_toggle_pair u_tog (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .stat_rd(stat_rd),
    .first_en(t1_en),
    .second_en(t2_en),
    .first_toggle_bit(tb1),
    .second_toggle_bit(tb2)
  );

  always @* begin
    st_d = st_q;
    case (st_q)
      S_READ: begin
        if (is_cmd(`FWS_CMD_PROG))
          st_d = S_PROG;
        else if (is_cmd(`FWS_CMD_BUF_PROG))
          st_d = S_BUF;
        else if (is_cmd(`FWS_CMD_SEC_ERASE))
          st_d = S_EWIN;
        else if (is_cmd(`FWS_CMD_CHIP_ERASE))
          st_d = S_ERASE;
      end
      S_EWIN: begin
        if (tmo_q == {`FWS_CNT_W{1'b0}} && !is_cmd(`FWS_CMD_SEC_ERASE))
          st_d = S_ERASE;
      end
      S_ERASE: begin
        if (is_cmd(`FWS_CMD_ERS_SUSP))
          st_d = S_ESUSP;
        else if (op_done && !limit_q)
          st_d = S_READ;
        else if (limit_q && is_cmd(`FWS_CMD_RESET))
          st_d = S_READ;
      end
      S_ESUSP: begin
        if (is_cmd(`FWS_CMD_ERS_RESUME))
          st_d = S_ERASE;
        else if (is_cmd(`FWS_CMD_PROG))
          st_d = S_ESPROG;
      end
      S_ESPROG: begin
        if (limit_q && is_cmd(`FWS_CMD_RESET))
          st_d = S_ESUSP;
        else if (op_done && !limit_q && !halt_q)
          st_d = S_ESUSP;
      end
      S_PROG: begin
        if (limit_q && is_cmd(`FWS_CMD_RESET))
          st_d = S_READ;
        else if (is_cmd(`FWS_CMD_PRG_SUSP) && !limit_q)
          st_d = S_PSUSP;
        else if (op_done && !limit_q && !halt_q)
          st_d = S_READ;
      end
      S_PSUSP: begin
        if (is_cmd(`FWS_CMD_PRG_RESUME))
          st_d = S_PROG;
      end
      S_BUF: begin
        if (abort_q && is_cmd(`FWS_CMD_ABORT_RESET))
          st_d = S_READ;
        else if (limit_q && is_cmd(`FWS_CMD_RESET))
          st_d = S_READ;
        else if (op_done && !limit_q && !abort_q && !halt_q)
          st_d = S_READ;
      end
      default: st_d = S_READ;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_READ;
      sel_q <= {`FWS_SECTORS{1'b0}};
      prog_sec_q <= 8'h00;
      tmo_q <= {`FWS_CNT_W{1'b0}};
      pulse_q <= {`FWS_CNT_W{1'b0}};
      limit_q <= 1'b0;
      abort_q <= 1'b0;
      halt_q <= 1'b0;
      chip_q <= 1'b0;
      poll7_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_d == S_READ) begin
        limit_q <= 1'b0;
        abort_q <= 1'b0;
        halt_q <= 1'b0;
        pulse_q <= {`FWS_CNT_W{1'b0}};
      end
      if (st_d == S_READ && st_q != S_READ)
        sel_q <= {`FWS_SECTORS{1'b0}};
      if (st_q == S_ESPROG && st_d == S_ESUSP) begin
        limit_q <= 1'b0;
        halt_q <= 1'b0;
        pulse_q <= {`FWS_CNT_W{1'b0}};
      end
      // Program and erase entry
      if (st_q == S_READ || st_q == S_ESUSP) begin
        if (is_cmd(`FWS_CMD_PROG) || (st_q == S_READ && is_cmd(`FWS_CMD_BUF_PROG))) begin
          prog_sec_q <= cmd_sector;
          poll7_q <= ~cmd_data[7];
          // Asking for a 1 where the array holds 0 can never succeed
          halt_q <= |(cmd_data & ~array_word);
          pulse_q <= {`FWS_CNT_W{1'b0}};
        end
      end
      if (st_q == S_BUF && is_cmd(`FWS_CMD_PROG) && !abort_q) begin
        poll7_q <= ~cmd_data[7];
        halt_q <= halt_q | (|(cmd_data & ~array_word));
      end
      if (st_q == S_BUF && is_cmd(`FWS_CMD_BUF_ABORT))
        abort_q <= 1'b1;
      if (st_q == S_READ && is_cmd(`FWS_CMD_CHIP_ERASE)) begin
        sel_q <= {`FWS_SECTORS{1'b1}};
        chip_q <= 1'b1;
      end
      if ((st_q == S_READ || st_q == S_EWIN) && is_cmd(`FWS_CMD_SEC_ERASE)) begin
        sel_q <= sel_q | cmd_hot;
        chip_q <= 1'b0;
        tmo_q <= ERASE_TMO_CYC[`FWS_CNT_W-1:0];
      end else if (st_q == S_EWIN && tmo_q != {`FWS_CNT_W{1'b0}})
        tmo_q <= tmo_q - 1'b1;
      // Pulse counting while an algorithm runs
      if ((st_q == S_PROG || st_q == S_ERASE || st_q == S_ESPROG || st_q == S_BUF) &&
          op_pulse && !limit_q && !abort_q) begin
        if (pulse_q >= PULSE_LIMIT[`FWS_CNT_W-1:0] - 1'b1)
          limit_q <= 1'b1;
        else
          pulse_q <= pulse_q + 1'b1;
      end
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
    end else if (stat_rd) begin
      rd_data <= rd_array;
      case (st_q)
        S_PROG, S_ESPROG, S_BUF: begin
          // Polling is only meaningful at the location being written
          rd_data[7:0] <= {(rd_sector == prog_sec_q) ? poll7_q : 1'b0, tb1, limit_q, 1'b0, 1'b0, 1'b0,
                           (st_q == S_BUF) ? abort_q : 1'b0, 1'b0};
        end
        S_EWIN, S_ERASE: begin
          rd_data[7:0] <= {1'b0, tb1, limit_q, 1'b0, (st_q == S_ERASE), tb2, 1'b0, 1'b0};
        end
        S_ESUSP: begin
          if (in_sel)
            rd_data[7:0] <= {1'b1, tb1, 1'b0, 1'b0, 1'b0, tb2, 1'b0, 1'b0};
        end
        S_PSUSP: begin
          // Data here may be mid-program and is not guaranteed
          if (rd_sector == prog_sec_q && rd_addr_last)
            rd_data <= 16'hffff;
        end
        default: rd_data <= rd_array;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- sim/fws_status_chk.sv
// Assertion checker for the status-word sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fws_consts.vh"
module fws_status_chk #(
  parameter ERASE_TMO_CYC = 20,
  parameter PULSE_LIMIT = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic stat_rd,
  input wire logic op_done,
  input wire logic [15:0] rd_data,
  input wire logic [2:0] state
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] win_q;
  wire sec = cmd_valid && cmd_code == `FWS_CMD_SEC_ERASE;
  // Cycles spent in the window since the last sector erase command
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      win_q <= 16'h0000;
    else if (state != 3'd2 || sec)
      win_q <= 16'h0000;
    else
      win_q <= win_q + 16'h0001;
  AST_OPEN: assert property (sec && state == 3'd0 |=> state == 3'd2)
    else $error("sector erase did not open the window");
  AST_CHIP: assert property (cmd_valid && cmd_code == `FWS_CMD_CHIP_ERASE && state == 3'd0 |=> state == 3'd3)
    else $error("chip erase went through the window");
  AST_RESTART: assert property (state == 3'd2 && sec |=> state == 3'd2 [*8])
    else $error("added sector did not restart the time-out");
  AST_TMO: assert property (state == 3'd2 |-> win_q <= ERASE_TMO_CYC + 2)
    else $error("erase window outlived its time-out");
  AST_WIN: assert property (stat_rd && state == 3'd2 |=> !rd_data[3])
    else $error("window flag high inside the time-out");
  AST_RUN: assert property (state == 3'd3 && cmd_valid && cmd_code == `FWS_CMD_PROG && !op_done |=> state == 3'd3)
    else $error("command accepted during erase");
  AST_ERS: assert property (stat_rd && state == 3'd3 |=> rd_data[3] && !rd_data[7])
    else $error("erase status encoding wrong");
  AST_TOG: assert property ((stat_rd && state == 3'd1) ##2 (stat_rd && state == 3'd1) |=> rd_data[6] != $past(rd_data[6]))
    else $error("first toggle bit did not toggle");
  AST_RST: assert property (state == 3'd1 && rd_data[5] && cmd_valid && cmd_code == `FWS_CMD_RESET |=> state == 3'd0)
    else $error("reset did not leave the failed program");
endmodule
bind fws_status fws_status_chk #(.ERASE_TMO_CYC(ERASE_TMO_CYC), .PULSE_LIMIT(PULSE_LIMIT)) chk_u (.ref_clk(ref_clk),
  .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .stat_rd(stat_rd), .op_done(op_done),
  .rd_data(rd_data), .state(state));
`default_nettype wire

//--- sim/fws_host.sv
// Host controller model issuing commands and status reads
`timescale 1ns/1ps
`default_nettype none
module fws_host (
  // Clock
  input wire logic ref_clk,
  // Command and read strobes
  output logic cmd_valid = 1'b0,
  output logic [3:0] cmd_code = 4'h0,
  output logic [7:0] cmd_sector = 8'h00,
  output logic [15:0] cmd_data = 16'h0000,
  output logic stat_rd = 1'b0,
  output logic [7:0] rd_sector = 8'h00
);
  // Released data and read-sector fields show the inverted value; code and sector keep the stale value
  task cmd(input logic [3:0] c, input logic [7:0] s, input logic [15:0] d);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_sector <= s;
    cmd_data <= d;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    cmd_data <= ~d;
  endtask
  task rd(input logic [7:0] s);
    @(posedge ref_clk);
    stat_rd <= 1'b1;
    rd_sector <= s;
    @(posedge ref_clk);
    stat_rd <= 1'b0;
    rd_sector <= ~s;
  endtask
endmodule
`default_nettype wire

//--- sim/flash_write_status_bits_tb.sv
// Self-checking bench for the status-word sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fws_consts.vh"
module flash_write_status_bits_tb;
  logic ref_clk = 1'b0, rst_n = 1'b0, op_pulse = 1'b0, op_done = 1'b0, p1 = 1'b0, last = 1'b0;
  logic cmd_valid, stat_rd, busy, erase_running;
  logic [3:0] cmd_code;
  logic [7:0] cmd_sector, rd_sector;
  logic [15:0] cmd_data, rd_data, array_word = 16'hffff, rd_array;
  logic [2:0] state;
  logic [31:0] q[$], n_q, rnd;
  integer err_count = 0, tests_run = 0, seed = 32'hc3f1;
  always #5 ref_clk = ~ref_clk;
  fws_host host_u (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_sector(cmd_sector),
    .cmd_data(cmd_data), .stat_rd(stat_rd), .rd_sector(rd_sector));
  fws_status #(.ERASE_TMO_CYC(20), .PULSE_LIMIT(4)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_sector(cmd_sector), .cmd_data(cmd_data),
    .array_word(array_word), .op_pulse(op_pulse), .op_done(op_done), .stat_rd(stat_rd), .rd_sector(rd_sector),
    .rd_addr_last(last), .rd_array(rd_array), .rd_data(rd_data), .busy(busy), .erase_running(erase_running),
    .state(state));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("checks=%0d errors=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Note mask and expected value, then read
  task rdx(input logic [15:0] m, input logic [15:0] e, input logic [7:0] s);
    q.push_back({m, e});
    host_u.rd(s);
  endtask
  task pls(input integer n, input logic done);
    repeat (n) begin
      @(posedge ref_clk);
      op_pulse <= !done;
      op_done <= done;
      @(posedge ref_clk);
      op_pulse <= 1'b0;
      op_done <= 1'b0;
    end
  endtask
  // Answer lands the cycle after the read is taken
  always @(posedge ref_clk) begin
    p1 <= stat_rd;
    if (p1 && q.size() > 0) begin
      n_q = q.pop_front();
      chk(rd_data & n_q[31:16], n_q[15:0]);
    end
  end
  initial begin
    rnd = $random(seed);
    rd_array = rnd[15:0];
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    host_u.cmd(`FWS_CMD_PROG, 8'd1, 16'h00f0);
    pls(4, 1'b0);
    rdx(16'h0022, 16'h0020, 8'd1);
    host_u.cmd(`FWS_CMD_RESET, 8'd1, 16'h0000);
    rdx(16'hffff, rd_array, 8'd1);
    array_word <= 16'h0000;
    host_u.cmd(`FWS_CMD_PROG, 8'd1, 16'h0001);
    pls(1, 1'b1);
    pls(4, 1'b0);
    rdx(16'h0020, 16'h0020, 8'd1);
    host_u.cmd(`FWS_CMD_RESET, 8'd1, 16'h0000);
    array_word <= 16'hffff;
    host_u.cmd(`FWS_CMD_SEC_ERASE, 8'd3, 16'h0000);
    rdx(16'h0008, 16'h0000, 8'd3);
    repeat (10) @(posedge ref_clk);
    host_u.cmd(`FWS_CMD_SEC_ERASE, 8'd5, 16'h0000);
    repeat (12) @(posedge ref_clk);
    rdx(16'h0008, 16'h0000, 8'd3);
    repeat (20) @(posedge ref_clk);
    rdx(16'h0088, 16'h0008, 8'd5);
    host_u.cmd(`FWS_CMD_PROG, 8'd5, 16'h0000);
    rdx(16'h0088, 16'h0008, 8'd5);
    pls(1, 1'b1);
    rdx(16'hffff, rd_array, 8'd3);
    host_u.cmd(`FWS_CMD_CHIP_ERASE, 8'd0, 16'h0000);
    rdx(16'h0008, 16'h0008, 8'd7);
    pls(1, 1'b1);
    rnd = $random(seed);
    host_u.cmd(`FWS_CMD_BUF_PROG, 8'd2, 16'h0000);
    host_u.cmd(`FWS_CMD_PROG, 8'd2, rnd[15:0]);
    rdx(16'h0080, {8'h00, ~rnd[7], 7'h00}, 8'd2);
    host_u.cmd(`FWS_CMD_BUF_ABORT, 8'd2, 16'h0000);
    rdx(16'h0002, 16'h0002, 8'd2);
    host_u.cmd(`FWS_CMD_ABORT_RESET, 8'd2, 16'h0000);
    rdx(16'hffff, rd_array, 8'd2);
    host_u.cmd(`FWS_CMD_PROG, 8'd4, 16'h1234);
    rdx(16'h00a0, 16'h0080, 8'd4);
    rdx(16'h00a0, 16'h0000, 8'd9);
    pls(1, 1'b1);
    host_u.cmd(`FWS_CMD_PROG, 8'd6, 16'h00ff);
    host_u.cmd(`FWS_CMD_PRG_SUSP, 8'd6, 16'h0000);
    last <= 1'b1;
    rdx(16'hffff, 16'hffff, 8'd6);
    last <= 1'b0;
    rdx(16'hffff, rd_array, 8'd7);
    host_u.cmd(`FWS_CMD_PRG_RESUME, 8'd6, 16'h0000);
    pls(1, 1'b1);
    rdx(16'hffff, rd_array, 8'd6);
    host_u.cmd(`FWS_CMD_SEC_ERASE, 8'd8, 16'h0000);
    repeat (25) @(posedge ref_clk);
    host_u.cmd(`FWS_CMD_ERS_SUSP, 8'd8, 16'h0000);
    rdx(16'h0088, 16'h0080, 8'd8);
    rdx(16'hffff, rd_array, 8'd9);
    host_u.cmd(`FWS_CMD_PROG, 8'd9, 16'h00ff);
    rdx(16'h00a0, 16'h0000, 8'd9);
    pls(1, 1'b1);
    host_u.cmd(`FWS_CMD_ERS_RESUME, 8'd8, 16'h0000);
    rdx(16'h0088, 16'h0008, 8'd8);
    pls(1, 1'b1);
    rdx(16'hffff, rd_array, 8'd8);
    repeat (3) @(posedge ref_clk);
    end_of_test;
  end
  // Hang guard: a stall counts as a mismatch
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count = err_count + 1;
    end_of_test;
  end
endmodule
`default_nettype wire
